// ===== logic/amp_cfg_params.svh
`ifndef AMP_CFG_PARAMS_SVH
`define AMP_CFG_PARAMS_SVH

// Control-port register offsets.
`define DIGITAL_CTRL_ADDR      8'h02
`define ANALOG_CONFIG_ADDR     8'h06

// Reset values.
`define DIGITAL_CTRL_RESET     8'h14
`define ANALOG_CONFIG_RESET    8'h00

// Analog configuration field positions.
`define PARALLEL_EN_BIT        7
`define AGAIN_HI_BIT           3
`define AGAIN_LO_BIT           2
`define CHAN_SEL_BIT           1

// Digital control field positions.
`define BOOST_HI_BIT           5
`define BOOST_LO_BIT           4
`define DOUBLE_SPEED_BIT       3

// Gain pin code that selects software control.
`define SW_MODE_GAIN_PINS      2'h3

// Core cycles the link is held in reset after rstn is released.
`define LINK_RST_CYCLES        10'h3FF

// Audio sample width and buffer depth.
`define SAMPLE_W               16
`define BUF_DEPTH              2

`endif

// ===== logic/amp_cfg_pkg.sv
package amp_cfg_pkg;

    // One stereo sample pair.
    typedef struct packed {
        logic [15:0] left;
        logic [15:0] right;
    } sample_pair_s;

    // Decoded configuration that steers the audio path.
    typedef struct packed {
        logic       parallel_bridge_mode;
        logic       chan_sel;
        logic [1:0] analog_path_gain;
        logic [1:0] digital_path_gain;
        logic       double_speed;
    } amp_config_s;

endpackage

// ===== logic/amp_cfg.sv
`timescale 1ns/10ps
`default_nettype none
`include "amp_cfg_params.svh"

module amp_cfg
    import amp_cfg_pkg::*;
(
    // Core clock and reset.
    input  wire logic                 core_clk,
    input  wire logic                 rstn,
    // Mode pins from the board.
    input  wire logic [1:0]           gain_pins,
    input  wire logic                 parallel_or_ctrl_clock_pin,
    // Decoded control-port register access.
    input  wire logic                 reg_wr,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata,
    // Serial audio link.
    input  wire logic                 bit_clk,
    input  wire logic                 frame_clk,
    input  wire logic                 serial_audio_input,
    // Processed audio towards the modulator.
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output sample_pair_s              out_data,
    // Configuration and status seen by the analog side.
    output amp_config_s               config_out,
    output logic                      software_mode,
    output logic                      overrun
);

    //--------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------
    logic [1:0] gain_meta, gain_sync;
    logic       par_meta, par_sync;

    // Board pins pass two flops before anything reads them.
    always_ff @(posedge core_clk) begin
        gain_meta <= gain_pins;
        gain_sync <= gain_meta;
        par_meta  <= parallel_or_ctrl_clock_pin;
        par_sync  <= par_meta;
    end

    //--------------------------------------------------------------
    // Control registers
    //--------------------------------------------------------------
    logic [7:0] analog_config, next_analog_config;
    logic [7:0] digital_ctrl, next_digital_ctrl;
    logic       sw_mode;

    assign sw_mode = (gain_sync == `SW_MODE_GAIN_PINS);

    // Writes only land in software mode; otherwise values are held.
    always_comb begin
        next_analog_config = analog_config;
        next_digital_ctrl  = digital_ctrl;
        if (reg_wr && sw_mode) begin
            if (reg_addr == `ANALOG_CONFIG_ADDR) begin
                next_analog_config = reg_wdata;
            end
            if (reg_addr == `DIGITAL_CTRL_ADDR) begin
                next_digital_ctrl = reg_wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            analog_config <= `ANALOG_CONFIG_RESET;
            digital_ctrl  <= `DIGITAL_CTRL_RESET;
        end else begin
            analog_config <= next_analog_config;
            digital_ctrl  <= next_digital_ctrl;
        end
    end

    // Read data comes from a flop so it is stable for the port serialiser.
    logic [7:0] next_reg_rdata;
    always_comb begin
        case (reg_addr)
            `ANALOG_CONFIG_ADDR: next_reg_rdata = analog_config;
            `DIGITAL_CTRL_ADDR:  next_reg_rdata = digital_ctrl;
            default:             next_reg_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    //--------------------------------------------------------------
    // Effective configuration
    //--------------------------------------------------------------
    amp_config_s next_cfg;

    // Hardware mode takes parallel from the pin and ignores soft-only features.
    always_comb begin
        next_cfg.parallel_bridge_mode = sw_mode ? analog_config[`PARALLEL_EN_BIT]
                                                : par_sync;
        next_cfg.chan_sel          = sw_mode & analog_config[`CHAN_SEL_BIT];
        next_cfg.analog_path_gain  = analog_config[`AGAIN_HI_BIT:`AGAIN_LO_BIT];
        next_cfg.digital_path_gain = digital_ctrl[`BOOST_HI_BIT:`BOOST_LO_BIT];
        next_cfg.double_speed      = sw_mode & digital_ctrl[`DOUBLE_SPEED_BIT];
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            config_out    <= '0;
            software_mode <= 1'b0;
        end else begin
            config_out    <= next_cfg;
            software_mode <= sw_mode;
        end
    end

    //--------------------------------------------------------------
    // Serial audio receiver, bit clock domain
    //--------------------------------------------------------------
    // Stretch the link reset so a slow bit clock sees it; very slow clocks need more.
    logic [9:0]  rst_wait, next_rst_wait;
    logic        link_rstn, next_link_rstn;
    assign next_rst_wait  = (rst_wait == `LINK_RST_CYCLES) ? rst_wait : rst_wait + 10'h001;
    assign next_link_rstn = (rst_wait == `LINK_RST_CYCLES);
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rst_wait  <= 10'h000;
            link_rstn <= 1'b0;
        end else begin
            rst_wait  <= next_rst_wait;
            link_rstn <= next_link_rstn;
        end
    end

    // The stretched reset reaches the link through two flops.
    logic        lrst_meta, lrst;
    logic        frame_d, frame_done_tgl;
    logic [15:0] shift, left_hold, pair_l, pair_r;
    logic [4:0]  bit_cnt;
    logic        next_frame_done_tgl;
    logic [15:0] next_shift, next_left_hold, next_pair_l, next_pair_r;
    logic [4:0]  next_bit_cnt;

    always_ff @(posedge bit_clk) begin
        lrst_meta <= link_rstn;
        lrst      <= lrst_meta;
    end

    // MSB first, one bit after each frame edge; extra bits beyond 16 are dropped,
    // so 48 and 64 fs bit clocks work; at 32 fs the LSB falls on the next edge cycle and is lost.
    always_comb begin
        next_shift          = shift;
        next_bit_cnt        = bit_cnt;
        next_left_hold      = left_hold;
        next_pair_l         = pair_l;
        next_pair_r         = pair_r;
        next_frame_done_tgl = frame_done_tgl;
        if (frame_d != frame_clk) begin
            next_bit_cnt = 5'h00;
            if (frame_clk) begin
                next_left_hold = shift;
            end else begin
                next_pair_l         = left_hold;
                next_pair_r         = shift;
                next_frame_done_tgl = ~frame_done_tgl;
            end
        end else if (bit_cnt < 5'h10) begin
            next_shift   = {shift[14:0], serial_audio_input};
            next_bit_cnt = bit_cnt + 5'h01;
        end
    end

    always_ff @(posedge bit_clk) begin
        if (!lrst) begin
            frame_d        <= 1'b0;
            shift          <= 16'h0000;
            bit_cnt        <= 5'h00;
            left_hold      <= 16'h0000;
            pair_l         <= 16'h0000;
            pair_r         <= 16'h0000;
            frame_done_tgl <= 1'b0;
        end else begin
            frame_d        <= frame_clk;
            shift          <= next_shift;
            bit_cnt        <= next_bit_cnt;
            left_hold      <= next_left_hold;
            pair_l         <= next_pair_l;
            pair_r         <= next_pair_r;
            frame_done_tgl <= next_frame_done_tgl;
        end
    end

    //--------------------------------------------------------------
    // Crossing and two-entry buffer, core domain
    //--------------------------------------------------------------
    // The pair stays still for a whole frame after the toggle, so it is safe to
    // sample once the synchronised toggle is seen.
    logic         tgl_meta, tgl_sync, tgl_seen;
    sample_pair_s buf_mem [`BUF_DEPTH];
    sample_pair_s next_wr_data, next_out_data;
    logic         wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [1:0]   count, next_count;
    logic         in_valid, in_ready, next_overrun, push, pop;

    // Boost is a left shift with saturation at full scale.
    function automatic logic [15:0] boost(input logic [15:0] s, input logic [1:0] g);
        logic signed [18:0] wide;
        wide = 19'(signed'(s)) <<< g;
        if (wide > 19'sh07FFF) begin
            boost = 16'h7FFF;
        end else if (wide < -19'sh08000) begin
            boost = 16'h8000;
        end else begin
            boost = wide[15:0];
        end
    endfunction

    assign in_valid = (tgl_sync != tgl_seen);
    assign in_ready = (count != 2'h2);
    assign push     = in_valid & in_ready;
    assign pop      = out_valid & out_ready;
    assign out_valid = (count != 2'h0);

    // Parallel mode feeds the chosen channel to both halves.
    always_comb begin
        logic [15:0] pick;
        pick = next_cfg.chan_sel ? pair_r : pair_l;
        if (next_cfg.parallel_bridge_mode) begin
            next_wr_data.left  = boost(pick, next_cfg.digital_path_gain);
            next_wr_data.right = boost(pick, next_cfg.digital_path_gain);
        end else begin
            next_wr_data.left  = boost(pair_l, next_cfg.digital_path_gain);
            next_wr_data.right = boost(pair_r, next_cfg.digital_path_gain);
        end
        next_wr_ptr  = wr_ptr ^ push;
        next_rd_ptr  = rd_ptr ^ pop;
        next_count   = count + {1'b0, push} - {1'b0, pop};
        // A full buffer cannot stall the audio source, so the loss is flagged.
        next_overrun = overrun | (in_valid & ~in_ready);
        // A word pushed into the slot that becomes the head bypasses the array.
        next_out_data = out_data;
        if (push && (next_rd_ptr == wr_ptr)) begin
            next_out_data = next_wr_data;
        end else if (next_count != 2'h0) begin
            next_out_data = buf_mem[next_rd_ptr];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn || !link_rstn) begin
            tgl_meta <= 1'b0;
            tgl_sync <= 1'b0;
            tgl_seen <= 1'b0;
            wr_ptr   <= 1'b0;
            rd_ptr   <= 1'b0;
            count    <= 2'h0;
            overrun  <= 1'b0;
            out_data <= '0;
        end else begin
            tgl_meta <= frame_done_tgl;
            tgl_sync <= tgl_meta;
            tgl_seen <= tgl_sync;
            wr_ptr   <= next_wr_ptr;
            rd_ptr   <= next_rd_ptr;
            count    <= next_count;
            overrun  <= next_overrun;
            out_data <= next_out_data;
            if (push) begin
                buf_mem[wr_ptr] <= next_wr_data;
            end
        end
    end

endmodule

`default_nettype wire

// ===== verif/amp_cfg_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ------
// Checks at the ports of the configuration block.
// ------
module amp_cfg_properties
    import amp_cfg_pkg::*;
(
    // Clock and reset.
    input wire logic         core_clk,
    input wire logic         rstn,
    // Register port and mode.
    input wire logic         reg_wr,
    input wire logic [7:0]   reg_addr,
    input wire logic [7:0]   reg_wdata,
    input wire logic [7:0]   reg_rdata,
    input wire logic         software_mode,
    input wire logic         parallel_or_ctrl_clock_pin,
    // Audio and configuration.
    input wire logic         out_valid,
    input wire logic         out_ready,
    input wire sample_pair_s out_data,
    input wire amp_config_s  config_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // Writes reach the configuration two cycles after the strobe.
    cfg_write_a: assert property (
        software_mode && reg_wr && reg_addr == 8'h06 |-> ##2 config_out[6:3] ==
        {$past(reg_wdata[7], 2), $past(reg_wdata[1], 2), $past(reg_wdata[3:2], 2)})
        else $error("analog write lost");
    boost_write_a: assert property (
        software_mode && reg_wr && reg_addr == 8'h02 |-> ##2
        config_out[2:0] == $past(reg_wdata[5:3], 2)) else $error("digital write lost");
    // Without a write the configuration must not drift.
    cfg_hold_a: assert property (
        (software_mode && !reg_wr) [*3] |=> $stable(config_out)) else $error("config drift");
    read_back_a: assert property (
        software_mode [*3] ##0 reg_addr == 8'h06 |=>
        {reg_rdata[7], reg_rdata[1], reg_rdata[3:2]} == config_out[6:3]) else $error("readback");
    reset_state_a: assert property (
        $rose(rstn) |-> config_out == '0 && !out_valid) else $error("reset state");
    // In hardware mode the pin sets the mode and software-only controls stay off.
    hw_pin_a: assert property (
        (!software_mode && $stable(parallel_or_ctrl_clock_pin)) [*5] |->
        config_out.parallel_bridge_mode == parallel_or_ctrl_clock_pin) else $error("pin mode");
    hw_locked_a: assert property (
        !software_mode [*3] |-> !config_out.chan_sel && !config_out.double_speed)
        else $error("hardware mode control");
    // A stalled word waits unchanged; pairs that arrive while the buffer is full are still dropped.
    stall_hold_a: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("stall lost");
endmodule
`default_nettype wire

// ===== verif/audio_source.sv
`timescale 1ns/10ps
`default_nettype none
// ------
// Serial audio source with 64 bit clocks a frame.
// ------
module audio_source
    import amp_cfg_pkg::*;
(
    // Link pins.
    output logic         bit_clk,
    output logic         frame_clk,
    output logic         serial_audio_input,
    // Pair sent in the next frame.
    input  wire sample_pair_s pair
);
    int          slot = 0;
    logic [63:0] sh;

    // An 80 ns clock, offset so that its edges fall midway between core clock edges.
    initial begin
        bit_clk = 1'b0;
        frame_clk = 1'b0;
        serial_audio_input = 1'b0;
        #13;
        forever #40 bit_clk = ~bit_clk;
    end

    // Frame low carries left, high right; a word starts one bit after the edge, MSB first.
    always @(negedge bit_clk) begin
        if (slot == 0) sh = {1'b0, pair.left, 16'h0, pair.right, 15'h0};
        frame_clk          <= slot >= 32;
        serial_audio_input <= sh[63 - slot];
        slot = (slot + 1) % 64;
    end
endmodule
`default_nettype wire

// ===== verif/amp_cfg_test.sv
`timescale 1ns/10ps
`default_nettype none
module amp_cfg_test
    import amp_cfg_pkg::*;
;
    // ------
    // Stimulus and observed signals.
    // ------
    logic         core_clk, rstn, reg_wr, out_ready, ctrl_pin;
    logic [1:0]   gain_pins;
    logic [7:0]   reg_addr, reg_wdata, reg_rdata;
    logic         bit_clk, frame_clk, sdata, out_valid, software_mode, overrun;
    sample_pair_s out_data, pair;
    amp_config_s  config_out;
    int           miscompares = 0;
    int           tests_run = 0;
    int           cycles = 0;

    amp_cfg dut (.core_clk(core_clk), .rstn(rstn), .gain_pins(gain_pins),
        .parallel_or_ctrl_clock_pin(ctrl_pin), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bit_clk(bit_clk), .frame_clk(frame_clk),
        .serial_audio_input(sdata), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .config_out(config_out), .software_mode(software_mode),
        .overrun(overrun));
    audio_source src (.bit_clk(bit_clk), .frame_clk(frame_clk), .serial_audio_input(sdata),
        .pair(pair));

    // A 4 ns core clock; a hang is cut short and counted as a mismatch.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        repeat (2) @(posedge core_clk);
        #1 chk({24'h0, reg_rdata}, {24'h0, exp});
    endtask
    // Old words are flushed for two frames before a fresh pair is taken.
    task automatic check_audio(input sample_pair_s exp);
        int n;
        @(posedge core_clk);
        out_ready <= 1'b1;
        repeat (2900) @(posedge core_clk);
        out_ready <= 1'b0;
        #1 n = 0;
        while (out_valid !== 1'b1 && n < 1400) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk(out_data, exp);
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        gain_pins = 2'h0;
        ctrl_pin = 1'b1;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        out_ready = 1'b0;
        pair = {16'h1234, 16'h9000};
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        wr(8'h06, 8'h02);
        repeat (6) @(posedge core_clk);
        #1 chk({29'h0, software_mode, config_out[6:5]}, 32'h2);
        @(posedge core_clk);
        ctrl_pin <= 1'b0;
        repeat (6) @(posedge core_clk);
        #1 chk({30'h0, config_out[6:5]}, 32'h0);
        @(posedge core_clk);
        gain_pins <= 2'h3;
        repeat (6) @(posedge core_clk);
        #1 chk({31'h0, software_mode}, 32'h1);
        rd(8'h06, 8'h00);
        rd(8'h02, 8'h14);
        rd(8'h3C, 8'h00);
        wr(8'h02, 8'h1C);
        rd(8'h02, 8'h1C);
        #1 chk({29'h0, config_out[2:0]}, 32'h3);
        check_audio({16'h2468, 16'h8000});
        pair <= {16'h1234, 16'h4321};
        for (int i = 0; i < 4; i++) begin
            wr(8'h06, {1'b1, 3'h0, i[1:0], i[0], 1'b0});
            rd(8'h06, {1'b1, 3'h0, i[1:0], i[0], 1'b0});
            #1 chk({28'h0, config_out[6:3]}, {28'h0, 1'b1, i[0], i[1:0]});
            check_audio(i[0] ? {16'h7FFF, 16'h7FFF} : {16'h2468, 16'h2468});
        end
        // A full buffer refuses the next pair and flags it; exactly two are held.
        repeat (5200) @(posedge core_clk);
        #1 chk({30'h0, overrun, out_valid}, 32'h3);
        @(posedge core_clk);
        out_ready <= 1'b1;
        repeat (2) @(posedge core_clk);
        out_ready <= 1'b0;
        #1 chk({31'h0, out_valid}, 32'h0);
        end_of_test();
    end
endmodule

bind amp_cfg amp_cfg_properties props (.core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .software_mode(software_mode), .parallel_or_ctrl_clock_pin(parallel_or_ctrl_clock_pin),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .config_out(config_out));
`default_nettype wire
